/* File: design/brsr_cfg.svh */
// brsr_cfg.svh: offsets, field positions, reset values and counts for the BER receive and rate register bank.
// assumes: included by its bare name; register indices are word indices, byte address is four times the index.
`ifndef BRSR_CFG_SVH
`define BRSR_CFG_SVH

`define BRSR_IDX_RX_LENGTH      10'h0CA
`define BRSR_IDX_RX_START       10'h0CB
`define BRSR_IDX_ERR_COUNT      10'h0CC
`define BRSR_IDX_LIN_BASE       10'h0CD
`define BRSR_IDX_LOUT_BASE      10'h0ED
`define BRSR_IDX_BIN_BASE       10'h10D

`define BRSR_LOCAL_STREAMS      16
`define BRSR_BP_STREAMS         32

`define BRSR_LEN_MSB            8
`define BRSR_LEN_LSB            0
`define BRSR_STREAM_MSB         13
`define BRSR_STREAM_LSB         9
`define BRSR_CHAN_MSB           8
`define BRSR_CHAN_LSB           0
`define BRSR_RATE_MSB           1
`define BRSR_RATE_LSB           0

`define BRSR_RESET_VALUE        16'h0000
`define BRSR_ERR_MAX            16'hFFFF

`endif

/* File: design/brsr_pkg.sv */
// brsr_pkg.sv: types shared by the register bank and its rate memory.
// assumes: brsr_cfg.svh is on the include path.
`include "brsr_cfg.svh"

package brsr_pkg;

	typedef enum logic [2:0] {
		BRSR_RATE_2M,
		BRSR_RATE_4M,
		BRSR_RATE_8M,
		BRSR_RATE_16M,
		BRSR_RATE_32M,
		BRSR_RATE_OFF
	} brsr_rate_e;

	typedef logic [1:0] brsr_code_t;

endpackage : brsr_pkg

/* File: design/brsr_rate_if.sv */
// brsr_rate_if.sv: write and read port between the register bank and its rate code store.
// assumes: one clock domain; the bank is the only writer.
`timescale 1ns/1ps

interface brsr_rate_if
	import brsr_pkg::*;
#(
	parameter int DEPTH = 64
);
	logic                     wr_en;
	logic [$clog2(DEPTH)-1:0] wr_addr;
	brsr_code_t               wr_code;
	logic [$clog2(DEPTH)-1:0] rd_addr;
	brsr_code_t               rd_code;
	brsr_code_t               codes [DEPTH];

	modport bank (output wr_en, output wr_addr, output wr_code, output rd_addr, input rd_code, input codes);
	modport store (input wr_en, input wr_addr, input wr_code, input rd_addr, output rd_code, output codes);
endinterface : brsr_rate_if

/* File: design/brsr_rate_mem.sv */
// brsr_rate_mem.sv: the 64 two-bit rate codes of all streams, registered read port plus parallel view.
// assumes: single clock, asynchronous active-low reset clears all codes.
`timescale 1ns/1ps

module brsr_rate_mem
	import brsr_pkg::*;
#(
	parameter int DEPTH = 64
) (
	input  wire logic   sys_clk_i,
	input  wire logic   resetn_i,
	brsr_rate_if.store  port
);

	brsr_code_t codes_q [DEPTH];
	brsr_code_t rd_q;

	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_code
			always_ff @(posedge sys_clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					codes_q[g] <= 2'h0;
				end else if (port.wr_en && (port.wr_addr == g)) begin
					codes_q[g] <= port.wr_code;
				end
			end
			assign port.codes[g] = codes_q[g];
		end
	endgenerate

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rd_q <= 2'h0;
		end else begin
			rd_q <= codes_q[port.rd_addr];
		end
	end

	assign port.rd_code = rd_q;

endmodule : brsr_rate_mem

/* File: design/brsr_regs.sv */
// brsr_regs.sv: backplane BER receive configuration, saturating error counter and per-stream rate registers.
// assumes: APB slave, 32-bit data, one word per register; fast-mode and count-clear come from a control block.
//
// How it works
// - receive window is length field plus one
// - stream select field picks checked stream
// - channel start field begins comparison
// - read-only sixteen bit error counter
// - counter saturates at FFFF until cleared
// - local input rate codes per stream
// - local fast mode overrides input rates
// - local output rate codes per stream
// - local fast mode overrides output rates
// - backplane input rate codes per stream
// - backplane fast mode overrides input rates
// - receive length at CA resets zero
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "brsr_cfg.svh"

module brsr_regs
	import brsr_pkg::*;
#(
	parameter int LSTREAMS = `BRSR_LOCAL_STREAMS,
	parameter int BSTREAMS = `BRSR_BP_STREAMS
) (
	input  wire logic        sys_clk_i,
	input  wire logic        resetn_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [31:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        local_fast_mode_i,
	input  wire logic        bp_fast_mode_i,
	input  wire logic        bp_count_clear_i,
	input  wire logic        bp_bit_error_i,
	output logic      [9:0]  rx_window_count_o,
	output logic      [4:0]  rx_stream_select_o,
	output logic      [8:0]  rx_channel_start_o,
	output logic      [15:0] bp_error_count_o,
	output brsr_rate_e       local_in_rate_o  [LSTREAMS],
	output brsr_rate_e       local_out_rate_o [LSTREAMS],
	output brsr_rate_e       bp_in_rate_o     [BSTREAMS]
);

	localparam int DEPTH = 2 * LSTREAMS + BSTREAMS;
	localparam int AW    = $clog2(DEPTH);

	typedef enum logic [1:0] {
		BRSR_IDLE,
		BRSR_READ_WAIT,
		BRSR_DONE
	} brsr_state_e;

	// decoded register target of an index
	typedef enum logic [2:0] {
		BRSR_T_LEN,
		BRSR_T_START,
		BRSR_T_COUNT,
		BRSR_T_RATE,
		BRSR_T_NONE
	} brsr_target_e;

	// rate bank that an index falls in; the three banks are not contiguous
	typedef enum logic [1:0] {
		BRSR_B_LIN,
		BRSR_B_LOUT,
		BRSR_B_BIN,
		BRSR_B_NONE
	} brsr_bank_e;

	brsr_state_e   state_q;
	brsr_state_e   state_d;
	brsr_target_e  tgt;
	brsr_bank_e    bank;
	logic [9:0]    idx;
	logic [AW-1:0] rate_addr;
	logic          misaligned;
	logic          lin_hit;
	logic          lout_hit;
	logic          bin_hit;
	logic [8:0]    rx_length_q;
	logic [13:0]   rx_start_q;
	logic [15:0]   err_count_q;
	logic [15:0]   err_count_d;
	logic          count_sat;
	logic [31:0]   rdata_q;
	logic [31:0]   rdata_d;
	logic          rdata_load;
	logic          slverr_q;
	logic          slverr_d;
	logic          setup;
	logic          rd_setup;
	logic          wr_fire;

	brsr_rate_if #(.DEPTH(DEPTH)) rate_bus ();

	brsr_rate_mem #(
		.DEPTH (DEPTH)
	) u_rate_mem (
		.sys_clk_i (sys_clk_i),
		.resetn_i  (resetn_i),
		.port      (rate_bus.store)
	);

	// true when i lies in [base, base + count)
	function automatic logic in_range(input logic [9:0] i, input logic [9:0] base, input int count);
		return (i >= base) && ({1'b0, i} < ({1'b0, base} + 11'(count)));
	endfunction : in_range

	function automatic brsr_bank_e bank_of(input logic [9:0] i);
		if (in_range(i, `BRSR_IDX_LIN_BASE, LSTREAMS)) begin
			return BRSR_B_LIN;
		end else if (in_range(i, `BRSR_IDX_LOUT_BASE, LSTREAMS)) begin
			return BRSR_B_LOUT;
		end else if (in_range(i, `BRSR_IDX_BIN_BASE, BSTREAMS)) begin
			return BRSR_B_BIN;
		end else begin
			return BRSR_B_NONE;
		end
	endfunction : bank_of

	// store layout: local in, then local out, then backplane in
	function automatic logic [AW-1:0] rate_index(input brsr_bank_e b, input logic [9:0] i);
		case (b)
			BRSR_B_LIN: begin
				return AW'(i - `BRSR_IDX_LIN_BASE);
			end
			BRSR_B_LOUT: begin
				return AW'(i - `BRSR_IDX_LOUT_BASE) + AW'(LSTREAMS);
			end
			BRSR_B_BIN: begin
				return AW'(i - `BRSR_IDX_BIN_BASE) + AW'(2 * LSTREAMS);
			end
			default: begin
				return AW'(0);
			end
		endcase
	endfunction : rate_index

	function automatic brsr_target_e decode(input logic [9:0] i);
		if (i == `BRSR_IDX_RX_LENGTH) begin
			return BRSR_T_LEN;
		end else if (i == `BRSR_IDX_RX_START) begin
			return BRSR_T_START;
		end else if (i == `BRSR_IDX_ERR_COUNT) begin
			return BRSR_T_COUNT;
		end else if (bank_of(i) != BRSR_B_NONE) begin
			return BRSR_T_RATE;
		end else begin
			return BRSR_T_NONE;
		end
	endfunction : decode

	// maps a two-bit code and a fast-mode flag to the stream rate
	function automatic brsr_rate_e rate_of(input brsr_code_t c, input logic fast, input logic low_half);
		if (fast) begin
			return low_half ? BRSR_RATE_32M : BRSR_RATE_OFF;
		end
		case (c)
			2'h0:    return BRSR_RATE_2M;
			2'h1:    return BRSR_RATE_4M;
			2'h2:    return BRSR_RATE_8M;
			default: return BRSR_RATE_16M;
		endcase
	endfunction : rate_of

	assign idx        = paddr_i[11:2];
	assign misaligned = (paddr_i[1:0] != 2'h0) || (paddr_i[31:12] != 20'h0);
	assign tgt        = misaligned ? BRSR_T_NONE : decode(idx);
	assign bank       = misaligned ? BRSR_B_NONE : bank_of(idx);
	assign lin_hit    = (bank == BRSR_B_LIN);
	assign lout_hit   = (bank == BRSR_B_LOUT);
	assign bin_hit    = (bank == BRSR_B_BIN);
	assign rate_addr  = rate_index(bank, idx);
	assign setup      = psel_i && !penable_i;
	assign rd_setup   = setup && !pwrite_i;
	assign wr_fire    = setup && pwrite_i && (tgt != BRSR_T_NONE) && (tgt != BRSR_T_COUNT);

	// writes land at the setup edge; reads take one wait for the registered rate store
	always_comb begin
		state_d = state_q;
		case (state_q)
			BRSR_IDLE: begin
				if (setup) begin
					state_d = pwrite_i ? BRSR_DONE : BRSR_READ_WAIT;
				end
			end
			BRSR_READ_WAIT: begin
				state_d = BRSR_DONE;
			end
			BRSR_DONE: begin
				state_d = BRSR_IDLE;
			end
			default: begin
				state_d = BRSR_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= BRSR_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	assign pready_o  = (state_q == BRSR_DONE);
	assign prdata_o  = rdata_q;
	assign pslverr_o = slverr_q;

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_length_q <= 9'(`BRSR_RESET_VALUE);
		end else if (wr_fire && tgt == BRSR_T_LEN) begin
			rx_length_q <= pwdata_i[`BRSR_LEN_MSB:`BRSR_LEN_LSB];
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_start_q <= 14'(`BRSR_RESET_VALUE);
		end else if (wr_fire && tgt == BRSR_T_START) begin
			rx_start_q <= pwdata_i[`BRSR_STREAM_MSB:0];
		end
	end

	assign count_sat = (err_count_q == `BRSR_ERR_MAX);

	// saturate, clear from control; an error in the clear cycle still counts
	always_comb begin
		err_count_d = err_count_q;
		if (bp_count_clear_i) begin
			err_count_d = bp_bit_error_i ? 16'h0001 : `BRSR_RESET_VALUE;
		end else if (bp_bit_error_i && !count_sat) begin
			err_count_d = err_count_q + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			err_count_q <= `BRSR_RESET_VALUE;
		end else begin
			err_count_q <= err_count_d;
		end
	end

	assign rate_bus.wr_en   = wr_fire && (tgt == BRSR_T_RATE);
	assign rate_bus.wr_addr = rate_addr;
	assign rate_bus.wr_code = pwdata_i[`BRSR_RATE_MSB:`BRSR_RATE_LSB];
	assign rate_bus.rd_addr = rate_addr;

	// read data; reserved bits read zero, rate codes arrive one cycle after setup
	always_comb begin
		rdata_load = 1'b0;
		rdata_d    = rdata_q;
		if (rd_setup) begin
			rdata_load = 1'b1;
			case (tgt)
				BRSR_T_LEN: begin
					rdata_d = {23'h0, rx_length_q};
				end
				BRSR_T_START: begin
					rdata_d = {18'h0, rx_start_q};
				end
				BRSR_T_COUNT: begin
					rdata_d = {16'h0, err_count_q};
				end
				default: begin
					rdata_d = 32'h0;
				end
			endcase
		end else if (state_q == BRSR_READ_WAIT && (lin_hit || lout_hit || bin_hit)) begin
			rdata_load = 1'b1;
			rdata_d    = {30'h0, rate_bus.rd_code};
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_q <= 32'h0;
		end else if (rdata_load) begin
			rdata_q <= rdata_d;
		end
	end

	// error response: unmapped index or a write to the count register
	always_comb begin
		slverr_d = slverr_q;
		if (setup) begin
			slverr_d = (tgt == BRSR_T_NONE) || (pwrite_i && tgt == BRSR_T_COUNT);
		end else if (state_q == BRSR_DONE) begin
			slverr_d = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			slverr_q <= 1'b0;
		end else begin
			slverr_q <= slverr_d;
		end
	end

	assign rx_window_count_o  = {1'b0, rx_length_q} + 10'h001;
	assign rx_stream_select_o = rx_start_q[`BRSR_STREAM_MSB:`BRSR_STREAM_LSB];
	assign rx_channel_start_o = rx_start_q[`BRSR_CHAN_MSB:`BRSR_CHAN_LSB];
	assign bp_error_count_o   = err_count_q;

	genvar g;
	generate
		for (g = 0; g < LSTREAMS; g++) begin : g_local
			assign local_in_rate_o[g]  = rate_of(rate_bus.codes[g], local_fast_mode_i, g < LSTREAMS / 2);
			assign local_out_rate_o[g] = rate_of(rate_bus.codes[LSTREAMS + g], local_fast_mode_i,
				g < LSTREAMS / 2);
		end
		for (g = 0; g < BSTREAMS; g++) begin : g_bp
			assign bp_in_rate_o[g] = rate_of(rate_bus.codes[2 * LSTREAMS + g], bp_fast_mode_i, g < BSTREAMS / 2);
		end
	endgenerate

endmodule : brsr_regs

/* File: dv/brsr_regs_monitor.sv */
// brsr_regs_monitor.sv: port-level assertions for the BER receive and rate register bank.
// assumes: bound into brsr_regs; sees only its ports.
`timescale 1ns/1ps

module brsr_regs_monitor
	import brsr_pkg::*;
#(
	parameter int LSTREAMS = 16,
	parameter int BSTREAMS = 32
) (
	input wire logic        sys_clk_i,
	input wire logic        resetn_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [31:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        local_fast_mode_i,
	input wire logic        bp_fast_mode_i,
	input wire logic        bp_count_clear_i,
	input wire logic        bp_bit_error_i,
	input wire logic [9:0]  rx_window_count_o,
	input wire logic [4:0]  rx_stream_select_o,
	input wire logic [8:0]  rx_channel_start_o,
	input wire logic [15:0] bp_error_count_o,
	input wire brsr_rate_e  local_in_rate_o  [LSTREAMS],
	input wire brsr_rate_e  local_out_rate_o [LSTREAMS],
	input wire brsr_rate_e  bp_in_rate_o     [BSTREAMS]
);
	logic wr_s;
	assign wr_s = psel_i && !penable_i && pwrite_i;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	chk_len_window: assert property (wr_s && paddr_i == 32'h328 |=>
		rx_window_count_o == $past(pwdata_i[9:0] & 10'h1FF) + 10'h001) else $error("window count wrong");
	chk_start_fields: assert property (wr_s && paddr_i == 32'h32C |=>
		{rx_stream_select_o, rx_channel_start_o} == $past(pwdata_i[13:0])) else $error("start fields wrong");
	chk_count_ro: assert property (wr_s && paddr_i == 32'h330 && !bp_bit_error_i && !bp_count_clear_i |=>
		$stable(bp_error_count_o) && pready_o && pslverr_o) else $error("count register written");
	chk_count_step: assert property (bp_bit_error_i && !bp_count_clear_i && bp_error_count_o != 16'hFFFF |=>
		bp_error_count_o == $past(bp_error_count_o) + 16'h0001) else $error("count step wrong");
	chk_count_sat: assert property (bp_error_count_o == 16'hFFFF && !bp_count_clear_i |=>
		bp_error_count_o == 16'hFFFF) else $error("count left saturation");
	chk_count_clear: assert property (bp_count_clear_i && !bp_bit_error_i |=>
		bp_error_count_o == 16'h0000) else $error("count not cleared");
	chk_local_fast: assert property (local_fast_mode_i |-> local_in_rate_o[7] == BRSR_RATE_32M &&
		local_in_rate_o[8] == BRSR_RATE_OFF && local_out_rate_o[0] == BRSR_RATE_32M &&
		local_out_rate_o[15] == BRSR_RATE_OFF) else $error("local fast mode rates wrong");
	chk_bp_fast: assert property (bp_fast_mode_i |-> bp_in_rate_o[15] == BRSR_RATE_32M &&
		bp_in_rate_o[16] == BRSR_RATE_OFF) else $error("backplane fast mode rates wrong");
	chk_read_wait: assert property (psel_i && !penable_i && !pwrite_i |=> !pready_o ##1 pready_o)
		else $error("read answer timing wrong");

	cover property (bp_error_count_o == 16'hFFFF);
	cover property (pready_o && pslverr_o);
	cover property (local_fast_mode_i && bp_fast_mode_i);
endmodule : brsr_regs_monitor

bind brsr_regs brsr_regs_monitor #(.LSTREAMS(LSTREAMS), .BSTREAMS(BSTREAMS)) brsr_regs_monitor_inst (
	.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .local_fast_mode_i(local_fast_mode_i), .bp_fast_mode_i(bp_fast_mode_i),
	.bp_count_clear_i(bp_count_clear_i), .bp_bit_error_i(bp_bit_error_i),
	.rx_window_count_o(rx_window_count_o), .rx_stream_select_o(rx_stream_select_o),
	.rx_channel_start_o(rx_channel_start_o), .bp_error_count_o(bp_error_count_o),
	.local_in_rate_o(local_in_rate_o), .local_out_rate_o(local_out_rate_o), .bp_in_rate_o(bp_in_rate_o));

/* File: dv/brsr_regs_tb_top.sv */
// brsr_regs_tb_top.sv: self-checking APB bench for the BER receive and rate register bank.
// assumes: brsr_pkg compiled and brsr_cfg.svh on the include path.
`timescale 1ns/1ps

module brsr_regs_tb_top;
	import brsr_pkg::*;
	logic        clk, rstn, psel, pen, pwr, lfm, bfm, clr, berr, pready, pslverr, se;
	logic [31:0] paddr, pwdata, prdata, rd, a;
	logic [9:0]  wcnt;
	logic [4:0]  ssel;
	logic [8:0]  cst;
	logic [15:0] ecnt;
	brsr_rate_e  lin [16];
	brsr_rate_e  lout [16];
	brsr_rate_e  bin [32];
	int          err_count, checks_done, cycles;

	brsr_regs brsr_regs_inst (.sys_clk_i(clk), .resetn_i(rstn), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .local_fast_mode_i(lfm), .bp_fast_mode_i(bfm), .bp_count_clear_i(clr),
		.bp_bit_error_i(berr), .rx_window_count_o(wcnt), .rx_stream_select_o(ssel),
		.rx_channel_start_o(cst), .bp_error_count_o(ecnt), .local_in_rate_o(lin),
		.local_out_rate_o(lout), .bp_in_rate_o(bin));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// one APB transfer; pready and data are taken at the edge where pready is high
	task automatic xfer(input logic w, input logic [31:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= ad; pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (pready !== 1'b1) begin
			err_count++;
			$display("ERROR %0t: no pready", $time);
		end
	endtask : xfer

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test

	always @(posedge clk) begin
		cycles++;
		if (cycles == 90000) begin
			err_count++;
			$display("ERROR %0t: timeout", $time);
			finish_test;
		end
	end

	function automatic logic [31:0] raddr(int k);
		return k < 16 ? 32'h334 + 4 * k : k < 32 ? 32'h3B4 + 4 * (k - 16) : 32'h434 + 4 * (k - 32);
	endfunction : raddr

	function automatic brsr_rate_e rout(int k);
		return k < 16 ? lin[k] : k < 32 ? lout[k - 16] : bin[k - 32];
	endfunction : rout

	initial begin
		rstn = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 32'h0; pwdata = 32'h0;
		lfm = 1'b0; bfm = 1'b0; clr = 1'b0; berr = 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk(32'(wcnt), 32'h1, "window after reset");
		xfer(1'b0, 32'h328, 32'h0);
		chk(rd, 32'h0, "length after reset");
		$display("reset test done");
		for (int k = 0; k < 64; k++) begin
			a = raddr(k);
			xfer(1'b0, a, 32'h0);
			chk(rd, 32'h0, "rate reg after reset");
			xfer(1'b1, a, 32'(k % 4));
			xfer(1'b0, a, 32'h0);
			chk(rd, 32'(k % 4), "rate readback");
			chk(32'(rout(k)), 32'(k % 4), "rate output");
		end
		@(posedge clk);
		lfm <= 1'b1; bfm <= 1'b1;
		@(negedge clk);
		for (int k = 0; k < 64; k++)
			chk(32'(rout(k)), (k < 8 || (k >= 16 && k < 24) || (k >= 32 && k < 48)) ? 32'(BRSR_RATE_32M) :
				32'(BRSR_RATE_OFF), "fast mode rate");
		@(posedge clk);
		lfm <= 1'b0; bfm <= 1'b0;
		$display("rate test done");
		for (int i = 0; i < 3; i++) begin
			a = i == 0 ? 32'h1F : i == 1 ? 32'h1FF : 32'h0;
			xfer(1'b1, 32'h328, a);
			chk(32'(wcnt), a + 32'h1, "window count");
			xfer(1'b0, 32'h328, 32'h0);
			chk(rd, a, "length readback");
		end
		xfer(1'b1, 32'h32C, {18'h0, 5'h15, 9'h1A5}); // reserved bits written zero
		chk({ssel, cst}, {5'h15, 9'h1A5}, "start fields");
		xfer(1'b0, 32'h32C, 32'h0);
		chk(rd, 32'h2BA5, "start readback");
		$display("receive setup test done");
		@(posedge clk) berr <= 1'b1;
		repeat (3) @(posedge clk);
		berr <= 1'b0;
		@(negedge clk);
		chk(32'(ecnt), 32'h3, "error count");
		xfer(1'b1, 32'h330, 32'h0000_FFFF);
		chk(32'(se), 32'h1, "count write refused");
		xfer(1'b0, 32'h330, 32'h0);
		chk(rd, 32'h3, "count unchanged");
		@(posedge clk) berr <= 1'b1;
		repeat (65540) @(posedge clk);
		berr <= 1'b0;
		@(negedge clk);
		chk(32'(ecnt), 32'hFFFF, "count saturated");
		@(posedge clk) clr <= 1'b1;
		@(posedge clk) clr <= 1'b0;
		@(negedge clk);
		chk(32'(ecnt), 32'h0, "count cleared");
		$display("counter test done");
		xfer(1'b0, 32'h600, 32'h0);
		chk({31'h0, se}, 32'h1, "unmapped error");
		chk(rd, 32'h0, "unmapped data");
		$display("unmapped test done");
		finish_test;
	end
endmodule : brsr_regs_tb_top
